// file: mode_standby_pkg.sv
// Shared constants and types for the processor mode and standby control.
// Assumes a 10 MHz aclk that stands in for the oscillator.
package mode_standby_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFF_MODE  = 8'h00;
	localparam logic [7:0] OFF_MISC2 = 8'h04;
	localparam logic [7:0] OFF_CMD   = 8'h08;
	localparam logic [7:0] OFF_STAT  = 8'h0C;
	localparam logic [7:0] OFF_TCTL  = 8'h10;
	localparam logic [7:0] OFF_T1    = 8'h14;
	localparam logic [7:0] OFF_IRQ   = 8'h18;
	localparam logic [7:0] OFF_PSW   = 8'h1C;

	// Processor mode codes
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_EXP    = 2'h1;
	localparam logic [1:0] MODE_MPU    = 2'h2;

	// Field positions
	localparam int MISC2_DBL  = 6;
	localparam int MISC2_CSEL = 1;
	localparam int MISC2_TSTP = 0;
	localparam int CMD_STOP   = 0;
	localparam int CMD_WAIT   = 1;
	localparam int TCTL_CEN   = 4;
	localparam int PSW_IFLAG  = 2;

	// Reset and load values
	localparam logic [7:0]  PSW_RST    = 8'h04;
	localparam logic [7:0]  T1_STOP_LO = 8'hFF;
	localparam logic [7:0]  T1_STOP_HI = 8'h03;
	localparam logic [15:0] T1_RST     = 16'hFFFF;

	// Timing: least instruction time before a new request bit shows
	localparam int CLK_PERIOD_NS = 100;
	localparam int INSTR_MIN_NS  = 800;
	localparam int IRQ_LAT_CYC   = (INSTR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Port P0-P2 usage
	typedef struct packed {
		logic p0_addr;
		logic p1_addr;
		logic p2_data;
		logic rom_en;
	} port_fn_t;

	typedef enum logic [1:0] {PS_RUN, PS_WAIT, PS_STOP, PS_WAKE} pstate_t;

endpackage : mode_standby_pkg

// file: mode_standby_ctrl.sv
// Processor mode selection, stop/wait standby and system clock generation.
// Assumes the CPU core pulses irq_accept and irq_set on aclk; the strap pin is asynchronous.
// How it works
// - Strap low at reset gives single-chip mode
// - Expansion mode: P0/P1 address, P2 data
// - Microprocessor mode disables internal ROM
// - Strap high forces microprocessor mode always
// - Strap low: software selects any mode
// - Stop halts oscillator, clock held high
// - Stop loads timer 03FF, sets forced flag in status bit 6
// - Forced source ends at overflow or reset
// - Interrupt restarts oscillator, clock waits overflow
// - Wait holds clock high; interrupt ends it
// - Leaving wait resumes at once
// - Misc bit 6 doubles bus cycle
// - Timers unaffected by bus doubling
// - Doubling also applies in single-chip mode
// - Reset low with strap high: programming mode
// - Interrupt request writes take effect late
// - Reset sets interrupt disable flag only
// - Mode bits sit in bits 1:0
// - Clock output div4, or div8 when doubled and misc bit 1 clear
`timescale 1ns/1ps
module mode_standby_ctrl (
	// Clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]                    s_awaddr,
	input  wire logic                          s_awvalid,
	output logic                               s_awready,
	input  wire logic [31:0]                   s_wdata,
	input  wire logic [3:0]                    s_wstrb,
	input  wire logic                          s_wvalid,
	output logic                               s_wready,
	output logic [1:0]                         s_bresp,
	output logic                               s_bvalid,
	input  wire logic                          s_bready,
	input  wire logic [7:0]                    s_araddr,
	input  wire logic                          s_arvalid,
	output logic                               s_arready,
	output logic [31:0]                        s_rdata,
	output logic [1:0]                         s_rresp,
	output logic                               s_rvalid,
	input  wire logic                          s_rready,
	// Pins and core side
	input  wire logic                          mode_select_pin,
	input  wire logic                          irq_accept,
	input  wire logic [7:0]                    irq_set,
	output mode_standby_pkg::port_fn_t         port_fn,
	output logic                               phi_out,
	output logic                               bus_strobe,
	output logic                               osc_run,
	output logic                               cpu_run,
	output logic                               eprom_mode
);

	////////////////////////////////////////////////////////////////////////
	// State
	logic [1:0]                  msel_s_r;
	logic                        msel_lock_r;
	logic [1:0]                  mode_r;
	logic [1:0]                  mode_eff;
	logic [7:0]                  misc2_r;
	logic [7:0]                  tctl_r;
	logic [7:0]                  psw_r;
	logic [7:0]                  irq_r;
	logic [7:0]                  irq_pend_r;
	logic [3:0]                  irq_cnt_r;
	logic [15:0]                 t1_r;
	logic                        forced_r;
	logic [1:0]                  pre_r;
	logic [2:0]                  div_r;
	mode_standby_pkg::pstate_t   ps_r;
	logic                        t1_tick;
	logic                        t1_ovf;
	logic                        dbl;
	logic                        aw_r;
	logic                        w_r;
	logic [7:0]                  awaddr_r;
	logic [31:0]                 wdata_r;
	logic [3:0]                  wstrb_r;
	logic                        wr_go;
	logic                        wr_hit;
	logic                        rd_hit;
	logic [31:0]                 rd_val;

	////////////////////////////////////////////////////////////////////////
	// Strap synchroniser; second stage feeds everything
	always_ff @(posedge aclk) begin
		msel_s_r <= {msel_s_r[0], mode_select_pin};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			msel_lock_r <= msel_s_r[1];
		end
	end

	// programming mode while held in reset
	always_ff @(posedge aclk) begin
		eprom_mode <= !aresetn && msel_s_r[1];
	end

	////////////////////////////////////////////////////////////////////////
	// AXI write channel: address and data taken in either order
	assign s_awready = !aw_r && !s_bvalid;
	assign s_wready  = !w_r && !s_bvalid;
	assign wr_go     = aw_r && w_r && !s_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_r     <= 1'b0;
			w_r      <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp  <= mode_standby_pkg::RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_r     <= 1'b1;
				awaddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_r     <= 1'b1;
				wdata_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (wr_go) begin
				aw_r     <= 1'b0;
				w_r      <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp  <= wr_hit ? mode_standby_pkg::RESP_OKAY
				                   : mode_standby_pkg::RESP_SLVERR;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Status register is read-only, so writes to it are refused too
	always_comb begin
		unique case (awaddr_r)
			mode_standby_pkg::OFF_MODE,  mode_standby_pkg::OFF_MISC2,
			mode_standby_pkg::OFF_CMD,   mode_standby_pkg::OFF_TCTL,
			mode_standby_pkg::OFF_T1,    mode_standby_pkg::OFF_IRQ,
			mode_standby_pkg::OFF_PSW:   wr_hit = 1'b1;
			default:                     wr_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Mode register
	// software mode select
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= mode_standby_pkg::MODE_SINGLE;
		end else if (wr_go && wstrb_r[0] && awaddr_r == mode_standby_pkg::OFF_MODE) begin
			mode_r <= wdata_r[1:0];
		end
	end

	assign mode_eff = msel_lock_r ? mode_standby_pkg::MODE_MPU : mode_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_fn <= '0;
		end else begin
			port_fn.p0_addr <= (mode_eff != mode_standby_pkg::MODE_SINGLE);
			port_fn.p1_addr <= (mode_eff != mode_standby_pkg::MODE_SINGLE);
			port_fn.p2_data <= (mode_eff != mode_standby_pkg::MODE_SINGLE);
			port_fn.rom_en  <= !mode_eff[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers that need no side effects beyond storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			misc2_r <= 8'h00;
			tctl_r  <= 8'h00;
		end else if (wr_go && wstrb_r[0]) begin
			if (awaddr_r == mode_standby_pkg::OFF_MISC2) begin
				misc2_r <= wdata_r[7:0];
			end
			if (awaddr_r == mode_standby_pkg::OFF_TCTL) begin
				tctl_r <= wdata_r[7:0];
			end
		end
	end

	// only the interrupt disable flag is set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			psw_r <= mode_standby_pkg::PSW_RST;
		end else if (wr_go && wstrb_r[0] && awaddr_r == mode_standby_pkg::OFF_PSW) begin
			psw_r <= wdata_r[7:0];
		end
	end

	// written value shows only after an instruction time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_r      <= 8'h00;
			irq_pend_r <= 8'h00;
			irq_cnt_r  <= 4'h0;
		end else begin
			irq_r <= irq_r | irq_set;
			if (wr_go && wstrb_r[0] && awaddr_r == mode_standby_pkg::OFF_IRQ) begin
				irq_pend_r <= wdata_r[7:0];
				irq_cnt_r  <= 4'(mode_standby_pkg::IRQ_LAT_CYC);
			end else if (irq_cnt_r != 4'h0) begin
				irq_cnt_r <= irq_cnt_r - 4'h1;
				// Set wins over a clear landing in the same cycle
				if (irq_cnt_r == 4'h1) begin
					irq_r <= irq_pend_r | irq_set;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Standby state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ps_r <= mode_standby_pkg::PS_RUN;
		end else begin
			unique case (ps_r)
				mode_standby_pkg::PS_RUN: begin
					if (wr_go && wstrb_r[0] && awaddr_r == mode_standby_pkg::OFF_CMD) begin
						if (wdata_r[mode_standby_pkg::CMD_STOP]) begin
							ps_r <= mode_standby_pkg::PS_STOP;
						end else if (wdata_r[mode_standby_pkg::CMD_WAIT]) begin
							ps_r <= mode_standby_pkg::PS_WAIT;
						end
					end
				end
				mode_standby_pkg::PS_WAIT: begin
					if (irq_accept) begin
						ps_r <= mode_standby_pkg::PS_RUN;
					end
				end
				mode_standby_pkg::PS_STOP: begin
					if (irq_accept) begin
						ps_r <= mode_standby_pkg::PS_WAKE;
					end
				end
				mode_standby_pkg::PS_WAKE: begin
					if (t1_ovf) begin
						ps_r <= mode_standby_pkg::PS_RUN;
					end
				end
			endcase
		end
	end

	assign osc_run = (ps_r != mode_standby_pkg::PS_STOP);
	assign cpu_run = (ps_r == mode_standby_pkg::PS_RUN);

	////////////////////////////////////////////////////////////////////////
	// Timer 1: own div4 prescaler, never touched by bus doubling
	// prescaler independent of doubling
	assign t1_tick = osc_run && pre_r == 2'h3 && tctl_r[mode_standby_pkg::TCTL_CEN];
	assign t1_ovf  = t1_tick && t1_r == 16'h0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_r <= 2'h0;
		end else if (osc_run) begin
			pre_r <= pre_r + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t1_r <= mode_standby_pkg::T1_RST;
		end else if (ps_r == mode_standby_pkg::PS_RUN && wr_go && wstrb_r[0]
		             && awaddr_r == mode_standby_pkg::OFF_CMD
		             && wdata_r[mode_standby_pkg::CMD_STOP]) begin
			t1_r <= {mode_standby_pkg::T1_STOP_HI, mode_standby_pkg::T1_STOP_LO};
		end else if (wr_go && awaddr_r == mode_standby_pkg::OFF_T1 && wstrb_r[1:0] == 2'h3) begin
			t1_r <= wdata_r[15:0];
		end else if (t1_ovf) begin
			t1_r <= mode_standby_pkg::T1_RST;
		end else if (t1_tick) begin
			t1_r <= t1_r - 16'h0001;
		end
	end

	// forced source cleared
	// Stop entry wins over an overflow in the same cycle, else the flag is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			forced_r <= 1'b0;
		end else if (ps_r == mode_standby_pkg::PS_RUN
		             && wr_go && wstrb_r[0] && awaddr_r == mode_standby_pkg::OFF_CMD
		             && wdata_r[mode_standby_pkg::CMD_STOP]) begin
			forced_r <= 1'b1;
		end else if (t1_ovf) begin
			forced_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// System clock and bus cycle
	// doubling bit
	assign dbl = misc2_r[mode_standby_pkg::MISC2_DBL];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_r <= 3'h0;
		end else if (osc_run) begin
			div_r <= div_r + 3'h1;
		end
	end

	// div4 or div8 on the clock pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phi_out    <= 1'b1;
			bus_strobe <= 1'b0;
		end else begin
			bus_strobe <= cpu_run && (dbl ? div_r == 3'h7 : div_r[1:0] == 2'h3);
			if (!cpu_run || misc2_r[mode_standby_pkg::MISC2_TSTP]) begin
				phi_out <= 1'b1;
			end else if (dbl && !misc2_r[mode_standby_pkg::MISC2_CSEL]) begin
				phi_out <= !div_r[2];
			end else begin
				phi_out <= !div_r[1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI read channel, one read at a time
	assign s_arready = !s_rvalid;

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_araddr)
			mode_standby_pkg::OFF_MODE:  rd_val[1:0] = mode_r;
			mode_standby_pkg::OFF_MISC2: rd_val[7:0] = misc2_r;
			mode_standby_pkg::OFF_CMD:   rd_val = 32'h0000_0000;
			mode_standby_pkg::OFF_STAT:  rd_val[6:0] = {forced_r, osc_run, ps_r,
			                                            msel_lock_r, mode_eff};
			mode_standby_pkg::OFF_TCTL:  rd_val[7:0] = tctl_r;
			mode_standby_pkg::OFF_T1:    rd_val[15:0] = t1_r;
			mode_standby_pkg::OFF_IRQ:   rd_val[7:0] = irq_r;
			mode_standby_pkg::OFF_PSW:   rd_val[7:0] = psw_r;
			default:                     rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0000_0000;
			s_rresp  <= mode_standby_pkg::RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rdata  <= rd_val;
			s_rresp  <= rd_hit ? mode_standby_pkg::RESP_OKAY : mode_standby_pkg::RESP_SLVERR;
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_single;
		$rose(aresetn) && !msel_lock_r |=> !port_fn.p0_addr && port_fn.rom_en;
	endproperty
	a_single: assert property (p_single) else $error("not single-chip after reset");

	property p_exp;
		mode_eff == mode_standby_pkg::MODE_EXP |=> port_fn.p1_addr && port_fn.p2_data;
	endproperty
	a_exp: assert property (p_exp) else $error("expansion ports wrong");

	property p_mpu;
		mode_eff[1] |=> !port_fn.rom_en && port_fn.p0_addr;
	endproperty
	a_mpu: assert property (p_mpu) else $error("ROM not disabled");

	property p_strap;
		msel_lock_r |-> mode_eff == mode_standby_pkg::MODE_MPU;
	endproperty
	a_strap: assert property (p_strap) else $error("strap not forcing mode");

	property p_stop;
		ps_r == mode_standby_pkg::PS_STOP |=> !osc_run || $past(irq_accept) ##0 phi_out;
	endproperty
	a_stop: assert property (p_stop) else $error("clock not frozen in stop");

	property p_preset;
		ps_r == mode_standby_pkg::PS_RUN ##1 ps_r == mode_standby_pkg::PS_STOP
		|-> t1_r == 16'h03FF && forced_r;
	endproperty
	a_preset: assert property (p_preset) else $error("stop preset missing");

	property p_wake;
		ps_r == mode_standby_pkg::PS_WAKE && !t1_ovf |=> phi_out && !cpu_run;
	endproperty
	a_wake: assert property (p_wake) else $error("clock released early");

	property p_wait;
		ps_r == mode_standby_pkg::PS_WAIT && irq_accept |=> cpu_run ##1 osc_run;
	endproperty
	a_wait: assert property (p_wait) else $error("wait exit delayed");

	property p_irqlat;
		wr_go && awaddr_r == mode_standby_pkg::OFF_IRQ && wstrb_r[0] && irq_set == 8'h00
		|=> (irq_r == ($past(irq_r) | $past(irq_set)))[*3];
	endproperty
	a_irqlat: assert property (p_irqlat) else $error("request write too early");

	property p_div8;
		cpu_run && div_r == 3'h3
		##1 cpu_run && dbl && !misc2_r[mode_standby_pkg::MISC2_CSEL]
		&& !misc2_r[mode_standby_pkg::MISC2_TSTP] |=> !phi_out;
	endproperty
	a_div8: assert property (p_div8) else $error("clock not divided by eight");

endmodule : mode_standby_ctrl

// file: core_irq_model.sv
// Core-side partner: turns a request into an accepted-interrupt pulse.
// Assumes one aclk domain; the bench drives req, int_enable and latency.
`timescale 1ns/1ps
module core_irq_model (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Bench side
	input  wire logic       req,
	input  wire logic       int_enable,
	input  wire logic [3:0] latency,
	// Toward the control block
	output logic            irq_accept
);
	logic [4:0] wait_r;

	////////////////////////////////////////////////////////////////////////
	// Acceptance after a chosen delay; a masked core never wakes
	// enable gates acceptance
	always_ff @(posedge aclk) begin
		irq_accept <= 1'b0;
		if (!aresetn) begin
			wait_r <= 5'h1F;
		end else if (req && int_enable) begin
			wait_r <= {1'b0, latency};
		end else if (wait_r == 5'h00) begin
			irq_accept <= 1'b1;
			wait_r     <= 5'h1F;
		end else if (wait_r != 5'h1F) begin
			wait_r <= wait_r - 5'h01;
		end
	end
endmodule : core_irq_model

// file: processor_mode_and_standby_control_tb.sv
// Self-checking bench for mode selection, standby and clock output.
// Assumes the design answers AXI4-Lite requests and uses aclk as oscillator.
`timescale 1ns/1ps
module processor_mode_and_standby_control_tb;
	logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
	logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
	logic [7:0]  s_awaddr, s_araddr, irq_set;
	logic [31:0] s_wdata, s_rdata, d, t_a, t_b, d1;
	logic [3:0]  s_wstrb, irq_lat;
	logic [1:0]  s_bresp, s_rresp, r;
	logic        mode_select_pin, irq_accept, irq_req, irq_en;
	logic        phi_out, bus_strobe, osc_run, cpu_run, eprom_mode;
	mode_standby_pkg::port_fn_t port_fn;
	int          num_errors, tests_run, i, p;
	logic [3:0]  pf_exp [4] = '{4'h1, 4'hF, 4'hE, 4'hE};

	mode_standby_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
		.s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
		.s_rready(s_rready), .mode_select_pin(mode_select_pin),
		.irq_accept(irq_accept), .irq_set(irq_set), .port_fn(port_fn),
		.phi_out(phi_out), .bus_strobe(bus_strobe), .osc_run(osc_run),
		.cpu_run(cpu_run), .eprom_mode(eprom_mode));

	core_irq_model core (.aclk(aclk), .aresetn(aresetn), .req(irq_req),
		.int_enable(irq_en), .latency(irq_lat), .irq_accept(irq_accept));

	////////////////////////////////////////////////////////////////////////
	// 10 MHz clock
	always #50 aclk = ~aclk;

	// Shared tasks
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got %08h exp %08h", $time, got, exp);
		end
	endtask : chk

	// Held four edges so the strap clears its synchroniser; flag read mid-cycle
	task automatic rst(input logic strap);
		@(posedge aclk);
		aresetn         <= 1'b0;
		mode_select_pin <= strap;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk(32'(eprom_mode), 32'(strap));
		@(posedge aclk);
		aresetn <= 1'b1;
	endtask : rst

	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		s_awaddr  <= a;
		s_wdata   <= v;
		s_awvalid <= 1'b1;
		s_wvalid  <= 1'b1;
		s_bready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_awvalid && s_awready) s_awvalid <= 1'b0;
			if (s_wvalid && s_wready) s_wvalid <= 1'b0;
			if (s_bvalid === 1'b1) break;
		end
		if (n == 50) chk(32'h0, 32'h1);
		rs = s_bresp;
		s_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		s_rready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_arvalid && s_arready) s_arvalid <= 1'b0;
			if (s_rvalid === 1'b1) break;
		end
		if (n == 50) chk(32'h0, 32'h1);
		v  = s_rdata;
		rs = s_rresp;
		s_rready <= 1'b0;
	endtask : axi_rd

	// Cycles between two rising edges of phi_out or bus_strobe
	task automatic period_of(input bit sel, output int pp);
		logic prv, cur;
		int   c, t0;
		prv = 1'b1;
		t0  = -1;
		pp  = 0;
		for (c = 0; c < 40 && pp == 0; c++) begin
			@(posedge aclk);
			cur = sel ? phi_out : bus_strobe;
			if (cur === 1'b1 && prv === 1'b0) begin
				if (t0 < 0) t0 = c;
				else pp = c - t0;
			end
			prv = cur;
		end
	endtask : period_of

	// Raise an interrupt and return at the edge where it is accepted
	task automatic wake;
		int n;
		@(posedge aclk);
		irq_req <= 1'b1;
		@(posedge aclk);
		irq_req <= 1'b0;
		for (n = 0; n < 20 && irq_accept !== 1'b1; n++) @(posedge aclk);
	endtask : wake

	// Timer 1 movement over 44 cycles, whole prescaler turns whatever the phase
	task automatic t1_delta(output logic [31:0] dl);
		axi_rd(mode_standby_pkg::OFF_T1, t_a, r);
		repeat (41) @(posedge aclk);
		axi_rd(mode_standby_pkg::OFF_T1, t_b, r);
		dl = t_a - t_b;
	endtask : t1_delta

	////////////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the longest stop recovery
	initial begin
		#2000000;
		num_errors++;
		wrap_up();
	end

	// Main sequence
	initial begin
		aclk = 0; aresetn = 0; s_awvalid = 0; s_wvalid = 0; s_bready = 0;
		s_arvalid = 0; s_rready = 0; s_awaddr = 0; s_araddr = 0; s_wdata = 0;
		s_wstrb = 4'hF; irq_set = 0; mode_select_pin = 0; irq_req = 0;
		irq_en = 0; irq_lat = 0; num_errors = 0; tests_run = 0;
		rst(1'b0);
		axi_rd(mode_standby_pkg::OFF_STAT, d, r);
		chk(d, 32'h20);
		chk(32'(port_fn), 32'h1);
		axi_rd(mode_standby_pkg::OFF_PSW, d, r);
		chk(d, 32'(mode_standby_pkg::PSW_RST));
		axi_rd(8'h20, d, r);
		chk({d[29:0], r}, {30'h0, mode_standby_pkg::RESP_SLVERR});
		axi_wr(mode_standby_pkg::OFF_STAT, 32'h3, r);
		chk(32'(r), 32'(mode_standby_pkg::RESP_SLVERR));
		$display("test reset_defaults done");

		for (i = 1; i < 5; i++) begin
			axi_wr(mode_standby_pkg::OFF_MODE, 32'(i % 4), r);
			repeat (3) @(posedge aclk);
			chk(32'(port_fn), 32'(pf_exp[i % 4]));
			axi_rd(mode_standby_pkg::OFF_STAT, d, r);
			chk(d & 32'h3, 32'(i % 4));
		end
		$display("test mode_switch done");

		axi_wr(mode_standby_pkg::OFF_TCTL, 32'h10, r);
		t1_delta(d1);
		chk(d1, 32'd11);
		axi_wr(mode_standby_pkg::OFF_MISC2, 32'h40, r);
		period_of(1'b0, p);
		chk(32'(p), 32'd8);
		period_of(1'b1, p);
		chk(32'(p), 32'd8);
		axi_wr(mode_standby_pkg::OFF_MISC2, 32'h42, r);
		period_of(1'b1, p);
		chk(32'(p), 32'd4);
		t1_delta(d);
		chk(d, d1);
		axi_wr(mode_standby_pkg::OFF_MISC2, 32'h00, r);
		period_of(1'b0, p);
		chk(32'(p), 32'd4);
		axi_wr(mode_standby_pkg::OFF_MISC2, 32'h01, r);
		period_of(1'b1, p);
		chk(32'(p), 32'd0);
		chk(32'(phi_out), 32'h1);
		axi_wr(mode_standby_pkg::OFF_MISC2, 32'h00, r);
		$display("test bus_double done");

		axi_wr(mode_standby_pkg::OFF_IRQ, 32'h01, r);
		axi_rd(mode_standby_pkg::OFF_IRQ, d, r);
		chk(d, 32'h0);
		repeat (10) @(posedge aclk);
		axi_rd(mode_standby_pkg::OFF_IRQ, d, r);
		chk(d, 32'h1);
		@(posedge aclk);
		irq_set <= 8'h02;
		@(posedge aclk);
		irq_set <= 8'h00;
		axi_rd(mode_standby_pkg::OFF_IRQ, d, r);
		chk(d, 32'h3);
		$display("test irq_delay done");

		irq_en  <= 1'b1;
		irq_lat <= 4'h3;
		axi_wr(mode_standby_pkg::OFF_CMD, 32'h2, r);
		repeat (6) @(posedge aclk);
		chk(32'({cpu_run, osc_run, phi_out}), 32'h3);
		wake();
		@(posedge aclk);
		chk(32'(cpu_run), 32'h1);
		$display("test wait_state done");

		// Timer holds still while its count enable is clear
		axi_wr(mode_standby_pkg::OFF_TCTL, 32'h00, r);
		axi_wr(mode_standby_pkg::OFF_T1, 32'h1234, r);
		repeat (8) @(posedge aclk);
		axi_rd(mode_standby_pkg::OFF_T1, d, r);
		chk(d, 32'h1234);
		axi_wr(mode_standby_pkg::OFF_TCTL, 32'h10, r);
		axi_wr(mode_standby_pkg::OFF_CMD, 32'h1, r);
		@(posedge aclk);
		chk(32'({cpu_run, osc_run, phi_out}), 32'h1);
		axi_rd(mode_standby_pkg::OFF_T1, d, r);
		chk(d, 32'h03FF);
		axi_rd(mode_standby_pkg::OFF_STAT, d, r);
		chk(d & 32'h40, 32'h40);
		irq_lat <= 4'h0;
		wake();
		@(posedge aclk);
		chk(32'({cpu_run, osc_run}), 32'h1);
		for (p = 0; p < 6000 && cpu_run !== 1'b1; p++) @(posedge aclk);
		chk(32'(p > 4080 && p < 4110), 32'h1);
		axi_rd(mode_standby_pkg::OFF_STAT, d, r);
		chk(d & 32'h40, 32'h0);
		$display("test stop_state done");

		axi_wr(mode_standby_pkg::OFF_CMD, 32'h1, r);
		rst(1'b1);
		axi_rd(mode_standby_pkg::OFF_STAT, d, r);
		chk(d, 32'h26);
		chk(32'(port_fn), 32'hE);
		chk(32'(eprom_mode), 32'h0);
		axi_wr(mode_standby_pkg::OFF_MODE, 32'h0, r);
		axi_rd(mode_standby_pkg::OFF_STAT, d, r);
		chk(d & 32'h3, 32'h2);
		$display("test strap_high done");
		wrap_up();
	end
endmodule : processor_mode_and_standby_control_tb
